// ==== src/pmc_defines.vh ====
// Constants for the transceiver mode control register block.
`ifndef PMC_DEFINES_VH
`define PMC_DEFINES_VH
`define PMC_REG_ADDR 5'h15
`define PMC_ERRCNT_ADDR 5'h18
`define PMC_BIT_FORCE_LINK_10 14
`define PMC_BIT_FORCE_LINK_100 13
`define PMC_BIT_JABBER_OFF 12
`define PMC_BIT_SEVEN_WIRE 11
`define PMC_BIT_ACT_LAMP 10
`define PMC_BIT_LAMP_SCHEME 9
`define PMC_BIT_FAR_FAULT_OFF 8
`define PMC_BIT_FAR_FAULT_SEND 7
`define PMC_BIT_ERR_FULL 6
`define PMC_BIT_ERR_OFF 5
`define PMC_BIT_WDT_OFF 4
`define PMC_BIT_RLOOP 3
`define PMC_BIT_SCRAMBLE 2
`define PMC_BIT_PCS_BYPASS 1
`define PMC_BIT_FIBRE 0
`define PMC_RW_MASK 16'h7FBF
`define PMC_CNT_RESET 16'h0000
`define PMC_CNT_FULL 16'hFFFF
`endif

// ==== src/pmc_err_counter.v ====
// Receive error event counter with full indication.
`timescale 1ns/10ps
`default_nettype none
module pmc_err_counter #(
  parameter WIDTH = 16
) (
  input wire clk, // System clock.
  input wire arst_n, // Asynchronous reset, active low.
  input wire enable, // Counting allowed.
  input wire event_in, // One receive error event.
  input wire load, // Software write of the count.
  input wire [WIDTH-1:0] load_value, // Value written.
  output reg [WIDTH-1:0] count, // Current count.
  output wire full // Count saturated.
);
  assign full = &count;

  // The count saturates so that the full indication stays meaningful.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= {WIDTH{1'b0}};
    end else if (load) begin
      count <= load_value;
    end else if (enable && event_in && !full) begin
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule
`default_nettype wire

// ==== src/pmc_mode_control.v ====
// Mode control register bank of a 10/100 transceiver.
// Notes on behaviour
// - Force 10M link up; also in local loopback.
// - Force 100M transmit ignoring link; negotiation off.
// - Jabber protection off when field is one.
// - Seven-wire interface only when coding sublayer used.
// - Activity lamp: receive only, or duplex-dependent.
// - Lamp scheme standard or advanced; strap reset.
// - Far fault off field, effective in fibre only.
// - Force far fault pattern regardless of detection.
// - Counter-full flag set at full; read clears.
// - Counter-disable field stops error counting.
// - Watchdog disable turns descrambler watchdog off.
// - Remote loopback in 100M when field one; not in fibre mode.
// - Scrambling field; forced zero in fibre mode.
// - Sixteen-bit receive error counter.
`timescale 1ns/10ps
`default_nettype none
`include "pmc_defines.vh"
module pmc_mode_control #(
  parameter CNT_WIDTH = 16
) (
  input wire SYS_CLK, // 250 MHz system clock.
  input wire ARST_N, // Asynchronous reset, active low.
  input wire [4:0] REG_ADDR, // Management register address.
  input wire REG_WR, // Write strobe, one cycle.
  input wire REG_RD, // Read strobe, one cycle.
  input wire [15:0] REG_WDATA, // Write data.
  output reg [15:0] REG_RDATA, // Read data, valid cycle after strobe.
  input wire STRAP_LAMP_SCHEME, // Strap level for lamp scheme.
  input wire STRAP_FAR_FAULT_OFF, // Strap level for far fault disable.
  input wire STRAP_SCRAMBLER, // Strap level for scrambling.
  input wire STRAP_PCS_BYPASS, // Strap level for coding sublayer bypass.
  input wire STRAP_FIBRE, // Strap level for fibre mode.
  input wire NLP_LINK_OK, // Normal link pulse check result.
  input wire LOCAL_LOOPBACK, // Local loopback active.
  input wire TX100_LINK_OK, // 100M link state.
  input wire JABBER_DETECT, // Raw jabber condition.
  input wire FULL_DUPLEX, // Duplex state.
  input wire RX_ACTIVE, // Receive activity.
  input wire TX_ACTIVE, // Transmit activity.
  input wire FAR_FAULT_DETECT, // Far fault seen on line.
  input wire RX_ERROR, // Receive error event.
  output reg LINK10_UP, // Reported 10M link.
  output reg TX100_ENABLE, // 100M transmit allowed.
  output reg JABBER_ACTIVE, // Jabber protection fired.
  output reg SEVEN_WIRE_ACTIVE, // Seven-wire interface in use.
  output reg ACTIVITY_LAMP, // Activity lamp drive.
  output reg LAMP_STANDARD, // Standard lamp scheme selected.
  output reg FAR_FAULT_SEND, // Transmit far fault pattern.
  output reg FAR_FAULT_SEEN, // Far fault detected and enabled.
  output reg WATCHDOG_ON, // Descrambler watchdog enabled.
  output reg REMOTE_LOOPBACK, // Line-side loopback in 100M.
  output reg SCRAMBLE_ON, // Scrambling active.
  output reg PCS_BYPASS, // Coding sublayer bypassed.
  output reg FIBRE_MODE // Fibre mode selected.
);
  //////////////////////////////////////////////////////////////////////////////
  reg [15:0] ctrl;
  reg [15:0] next_ctrl;
  reg [15:0] next_rdata;
  reg err_full_flag;
  reg next_err_full_flag;
  reg next_lamp;
  reg strap_taken;
  wire [CNT_WIDTH-1:0] err_count;
  wire err_full;
  wire wr_ctrl;
  wire rd_ctrl;
  wire wr_cnt;
  wire rd_cnt;
  wire fibre;
  wire far_fault_hit;

  // True when a strobe addresses the given register.
  function reg_hit;
    input strobe;
    input [4:0] addr;
    input [4:0] target;
    begin
      reg_hit = strobe && (addr == target);
    end
  endfunction

  assign wr_ctrl = reg_hit(REG_WR, REG_ADDR, `PMC_REG_ADDR);
  assign rd_ctrl = reg_hit(REG_RD, REG_ADDR, `PMC_REG_ADDR);
  assign wr_cnt = reg_hit(REG_WR, REG_ADDR, `PMC_ERRCNT_ADDR);
  assign rd_cnt = reg_hit(REG_RD, REG_ADDR, `PMC_ERRCNT_ADDR);
  assign fibre = ctrl[`PMC_BIT_FIBRE];
  // Far fault detection counts only in fibre mode and while not disabled.
  assign far_fault_hit = fibre & ~ctrl[`PMC_BIT_FAR_FAULT_OFF] & FAR_FAULT_DETECT;

  pmc_err_counter #(.WIDTH(CNT_WIDTH)) u_cnt (
    .clk(SYS_CLK),
    .arst_n(ARST_N),
    .enable(~ctrl[`PMC_BIT_ERR_OFF]),
    .event_in(RX_ERROR),
    .load(wr_cnt),
    .load_value(REG_WDATA[CNT_WIDTH-1:0]),
    .count(err_count),
    .full(err_full)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Next control word; straps land once, on the first edge after reset release.
  always @* begin
    next_ctrl = ctrl;
    if (!strap_taken) begin
      next_ctrl[`PMC_BIT_LAMP_SCHEME] = STRAP_LAMP_SCHEME;
      next_ctrl[`PMC_BIT_FAR_FAULT_OFF] = STRAP_FAR_FAULT_OFF;
      next_ctrl[`PMC_BIT_SCRAMBLE] = STRAP_SCRAMBLER;
      next_ctrl[`PMC_BIT_PCS_BYPASS] = STRAP_PCS_BYPASS;
      next_ctrl[`PMC_BIT_FIBRE] = STRAP_FIBRE;
    end else if (wr_ctrl) begin
      next_ctrl = REG_WDATA & `PMC_RW_MASK;
    end
    // Scrambling cannot stay on in fibre mode, whatever was written or strapped.
    if (next_ctrl[`PMC_BIT_FIBRE]) begin
      next_ctrl[`PMC_BIT_SCRAMBLE] = 1'b0;
    end
  end

  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl <= 16'h0000;
      strap_taken <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      strap_taken <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Full flag: a set in the same cycle as a clearing read wins.
  always @* begin
    next_err_full_flag = err_full_flag;
    if (err_full) begin
      next_err_full_flag = 1'b1;
    end else if (rd_ctrl) begin
      next_err_full_flag = 1'b0;
    end
  end

  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      err_full_flag <= 1'b0;
    end else begin
      err_full_flag <= next_err_full_flag;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data holds between reads; unmapped addresses read as zero.
  always @* begin
    next_rdata = REG_RDATA;
    if (rd_ctrl) begin
      next_rdata = {ctrl[15:7], err_full_flag, ctrl[5:0]};
    end else if (rd_cnt) begin
      next_rdata = err_count;
    end else if (REG_RD) begin
      next_rdata = 16'h0000;
    end
  end

  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      REG_RDATA <= 16'h0000;
    end else begin
      REG_RDATA <= next_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Activity lamp: receive only when so configured or in full duplex.
  always @* begin
    if (ctrl[`PMC_BIT_ACT_LAMP] || FULL_DUPLEX) begin
      next_lamp = RX_ACTIVE;
    end else begin
      next_lamp = RX_ACTIVE | TX_ACTIVE;
    end
  end

  // Link, transmit and protection overrides.
  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      LINK10_UP <= 1'b0;
      TX100_ENABLE <= 1'b0;
      JABBER_ACTIVE <= 1'b0;
      WATCHDOG_ON <= 1'b0;
    end else begin
      LINK10_UP <= ctrl[`PMC_BIT_FORCE_LINK_10] | LOCAL_LOOPBACK | NLP_LINK_OK;
      TX100_ENABLE <= ctrl[`PMC_BIT_FORCE_LINK_100] | TX100_LINK_OK;
      JABBER_ACTIVE <= JABBER_DETECT & ~ctrl[`PMC_BIT_JABBER_OFF];
      WATCHDOG_ON <= ~ctrl[`PMC_BIT_WDT_OFF];
    end
  end

  // Interface and lamp selection.
  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SEVEN_WIRE_ACTIVE <= 1'b0;
      ACTIVITY_LAMP <= 1'b0;
      LAMP_STANDARD <= 1'b0;
      PCS_BYPASS <= 1'b0;
    end else begin
      SEVEN_WIRE_ACTIVE <= ctrl[`PMC_BIT_SEVEN_WIRE] & ~ctrl[`PMC_BIT_PCS_BYPASS];
      ACTIVITY_LAMP <= next_lamp;
      LAMP_STANDARD <= ctrl[`PMC_BIT_LAMP_SCHEME];
      PCS_BYPASS <= ctrl[`PMC_BIT_PCS_BYPASS];
    end
  end

  // Line coding, loopback and far-end fault.
  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      FAR_FAULT_SEND <= 1'b0;
      FAR_FAULT_SEEN <= 1'b0;
      REMOTE_LOOPBACK <= 1'b0;
      SCRAMBLE_ON <= 1'b0;
      FIBRE_MODE <= 1'b0;
    end else begin
      FAR_FAULT_SEND <= ctrl[`PMC_BIT_FAR_FAULT_SEND] | far_fault_hit;
      FAR_FAULT_SEEN <= far_fault_hit;
      REMOTE_LOOPBACK <= ctrl[`PMC_BIT_RLOOP] & ~fibre;
      SCRAMBLE_ON <= ctrl[`PMC_BIT_SCRAMBLE] & ~fibre;
      FIBRE_MODE <= fibre;
    end
  end
endmodule
`default_nettype wire

// ==== tb/pmc_chk.sv ====
// Port assertions for the mode control register bank.
`timescale 1ns/10ps
`default_nettype none
module pmc_chk #(
  parameter CNT_WIDTH = 16
) (
  input wire logic SYS_CLK, // Clock.
  input wire logic ARST_N, // Reset.
  input wire logic NLP_LINK_OK, // In.
  input wire logic LOCAL_LOOPBACK, // In.
  input wire logic TX100_LINK_OK, // In.
  input wire logic JABBER_DETECT, // In.
  input wire logic FULL_DUPLEX, // In.
  input wire logic RX_ACTIVE, // In.
  input wire logic FAR_FAULT_DETECT, // In.
  input wire logic LINK10_UP, // Out.
  input wire logic TX100_ENABLE, // Out.
  input wire logic JABBER_ACTIVE, // Out.
  input wire logic SEVEN_WIRE_ACTIVE, // Out.
  input wire logic ACTIVITY_LAMP, // Out.
  input wire logic FAR_FAULT_SEEN, // Out.
  input wire logic REMOTE_LOOPBACK, // Out.
  input wire logic SCRAMBLE_ON, // Out.
  input wire logic PCS_BYPASS, // Out.
  input wire logic FIBRE_MODE // Out.
);
  logic [1:0] up_cnt;
  wire up = up_cnt == 2'h3;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);
  // Holds off, for three cycles after reset, the checks that need a full cycle of inputs.
  always_ff @(posedge SYS_CLK or negedge ARST_N)
    if (!ARST_N) up_cnt <= 2'h0;
    else if (!up) up_cnt <= up_cnt + 2'h1;
  AST_LINK10: assert property (up && $past(NLP_LINK_OK | LOCAL_LOOPBACK) |-> LINK10_UP) else $error("link10 low");
  AST_TX100: assert property (up && $past(TX100_LINK_OK) |-> TX100_ENABLE) else $error("tx100 off");
  AST_JAB: assert property (JABBER_ACTIVE |-> $past(JABBER_DETECT)) else $error("jabber no cause");
  AST_SEVEN: assert property (SEVEN_WIRE_ACTIVE |-> !PCS_BYPASS) else $error("seven wire in bypass");
  AST_LAMPFD: assert property ($past(FULL_DUPLEX & ~RX_ACTIVE) |-> !ACTIVITY_LAMP) else $error("lamp on");
  AST_LAMPRX: assert property (up && $past(RX_ACTIVE) |-> ACTIVITY_LAMP) else $error("lamp off");
  AST_FAULT: assert property (FAR_FAULT_SEEN |-> FIBRE_MODE && $past(FAR_FAULT_DETECT)) else $error("fault");
  AST_FIBRE: assert property (FIBRE_MODE |-> !SCRAMBLE_ON && !REMOTE_LOOPBACK) else $error("fibre");
endmodule
bind pmc_mode_control pmc_chk #(.CNT_WIDTH(CNT_WIDTH)) chk_i (.*);
`default_nettype wire

// ==== tb/pmc_mac_model.sv ====
// Behavioural far side that drives status levels and error events.
`timescale 1ns/10ps
`default_nettype none
module pmc_mac_model (
  input wire logic clk, // Clock.
  input wire logic [7:0] pat, // Levels asked for.
  input wire logic err_on, // Emit error events.
  output logic [7:0] lv = 8'h00, // Status levels.
  output logic rx_err = 1'b0 // One pulse per event.
);
  // This side never negotiates, so a forced 100M link is always legal.
  always @(posedge clk) begin
    lv <= pat;
    rx_err <= err_on & ~rx_err;
  end
endmodule
`default_nettype wire

// ==== tb/pmc_mode_control_tb.sv ====
// Self-checking bench for the mode control register bank.
`timescale 1ns/10ps
`default_nettype none
module pmc_mode_control_tb;
  logic SYS_CLK = 1'b0, ARST_N = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0, err_on = 1'b0;
  logic STRAP_LAMP_SCHEME = 1'b1, STRAP_FAR_FAULT_OFF = 1'b0, STRAP_SCRAMBLER = 1'b1;
  logic STRAP_PCS_BYPASS = 1'b0, STRAP_FIBRE = 1'b0;
  logic [4:0] REG_ADDR = 5'h00;
  logic [15:0] REG_WDATA = 16'h0000, REG_RDATA, outs;
  logic [7:0] pat = 8'h00;
  logic LINK10_UP, TX100_ENABLE, JABBER_ACTIVE, SEVEN_WIRE_ACTIVE, ACTIVITY_LAMP, LAMP_STANDARD, FAR_FAULT_SEND;
  logic FAR_FAULT_SEEN, WATCHDOG_ON, REMOTE_LOOPBACK, SCRAMBLE_ON, PCS_BYPASS, FIBRE_MODE;
  wire NLP_LINK_OK, LOCAL_LOOPBACK, TX100_LINK_OK, JABBER_DETECT, FULL_DUPLEX, RX_ACTIVE, TX_ACTIVE;
  wire FAR_FAULT_DETECT, RX_ERROR;
  int err_count = 0, checks_done = 0;
  assign outs = {3'h0, LINK10_UP, TX100_ENABLE, JABBER_ACTIVE, SEVEN_WIRE_ACTIVE, ACTIVITY_LAMP, LAMP_STANDARD,
    FAR_FAULT_SEND, FAR_FAULT_SEEN, WATCHDOG_ON, REMOTE_LOOPBACK, SCRAMBLE_ON, PCS_BYPASS, FIBRE_MODE};
  pmc_mode_control uut (.*);
  pmc_mac_model mac (.clk(SYS_CLK), .pat(pat), .err_on(err_on), .rx_err(RX_ERROR), .lv({NLP_LINK_OK,
    LOCAL_LOOPBACK, TX100_LINK_OK, JABBER_DETECT, FULL_DUPLEX, RX_ACTIVE, TX_ACTIVE, FAR_FAULT_DETECT}));
  initial forever #2 SYS_CLK = ~SYS_CLK;
  ////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    if (err_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge SYS_CLK) {REG_ADDR, REG_WDATA, REG_WR} <= {a, d, 1'b1};
    @(posedge SYS_CLK) REG_WR <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
    #1;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge SYS_CLK) {REG_ADDR, REG_RD} <= {a, 1'b1};
    @(posedge SYS_CLK) REG_RD <= 1'b0;
    #1 chk("rdata", REG_RDATA, e);
  endtask
  task automatic errs;
    @(posedge SYS_CLK) err_on <= 1'b1;
    repeat (10) @(posedge SYS_CLK);
    err_on <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3000) @(posedge SYS_CLK);
    err_count++;
    summarize;
  end
  initial begin
    repeat (8) @(posedge SYS_CLK);
    ARST_N <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    #1 chk("outs", outs, 16'h0094);
    rd(5'h15, 16'h0204);
    rd(5'h00, 16'h0000);
    wr(5'h15, 16'hFFFF);
    rd(5'h15, 16'h7FBB);
    chk("outs", outs, 16'h18C3);
    pat <= 8'h13;
    wr(5'h15, 16'h7C08);
    chk("outs", outs, 16'h1A18);
    wr(5'h15, 16'h0000);
    chk("outs", outs, 16'h0510);
    wr(5'h15, 16'h0001);
    chk("outs", outs, 16'h0571);
    wr(5'h15, 16'h0101);
    chk("outs", outs, 16'h0511);
    pat <= 8'h40;
    wr(5'h15, 16'h0802);
    chk("outs", outs, 16'h1012);
    wr(5'h18, 16'hFFFD);
    errs();
    rd(5'h18, 16'hFFFF);
    rd(5'h15, 16'h0842);
    wr(5'h18, 16'h0000);
    rd(5'h15, 16'h0842);
    rd(5'h15, 16'h0802);
    wr(5'h15, 16'h0020);
    errs();
    rd(5'h18, 16'h0000);
    pat <= 8'hAA;
    repeat (3) @(posedge SYS_CLK);
    #1 chk("outs", outs, 16'h1810);
    pat <= 8'h04;
    repeat (3) @(posedge SYS_CLK);
    #1 chk("outs", outs, 16'h0110);
    {STRAP_LAMP_SCHEME, STRAP_FAR_FAULT_OFF, STRAP_PCS_BYPASS, STRAP_FIBRE} <= 4'h7;
    @(posedge SYS_CLK) ARST_N <= 1'b0;
    repeat (8) @(posedge SYS_CLK);
    ARST_N <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    #1 chk("outs", outs, 16'h0113);
    rd(5'h15, 16'h0103);
    summarize;
  end
endmodule
`default_nettype wire
